// file: ksc_pkg.sv
// Package of constants and types for the key-scan configuration block
`default_nettype none
package ksc_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_DEBOUNCE = 8'h02;
	localparam logic [7:0] ADDR_ALERT_CFG = 8'h03;
	localparam logic [7:0] ADDR_PORT_OUT = 8'h04;
	localparam logic [7:0] ADDR_REPEAT = 8'h05;
	// Reset values
	localparam logic [7:0] RST_DEBOUNCE = 8'hff;
	localparam logic [7:0] RST_ALERT_CFG = 8'h00;
	localparam logic [7:0] RST_PORT_OUT = 8'hfe;
	localparam logic [7:0] RST_REPEAT = 8'h00;
	// Field positions
	localparam int DEB_TIME_LSB = 0;
	localparam int DEB_TIME_MSB = 4;
	localparam int DEB_PORTS_LSB = 5;
	localparam int DEB_PORTS_MSB = 7;
	localparam int ALR_TIME_LSB = 0;
	localparam int ALR_TIME_MSB = 4;
	localparam int ALR_FIFO_LSB = 5;
	localparam int ALR_FIFO_MSB = 7;
	localparam int PORT_ALERT_BIT = 1;
	localparam int PORT_COL_LSB = 2;
	localparam int PORT_COL_MSB = 7;
	localparam logic [7:0] PORT_WR_MASK = 8'hfe;
	localparam int RPT_DELAY_LSB = 0;
	localparam int RPT_DELAY_MSB = 3;
	localparam int RPT_RATE_LSB = 4;
	localparam int RPT_RATE_MSB = 6;
	localparam int RPT_EN_BIT = 7;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_IN_NS = 1000000;
	localparam int MS_CYCLES = MS_IN_NS / CLK_PERIOD_NS;
	localparam logic [5:0] DEB_BASE_MS = 6'h09;
	localparam int DELAY_SHIFT = 3;
	localparam int RATE_SHIFT = 2;
	// Codes
	localparam logic [7:0] REPEAT_CODE = 8'h7e;
	localparam int NUM_COLS = 6;
	// Autorepeat sequencer states
	typedef enum logic [1:0] {AR_IDLE, AR_DELAY, AR_REPEAT} ksc_ar_t;
	// Complete block state
	typedef struct packed {
		logic [7:0] deb_q;
		logic [7:0] alr_q;
		logic [7:0] port_q;
		logic [7:0] rpt_q;
		logic [7:0] rdata_q;
		logic [16:0] ms_cnt_q;
		logic [5:0] deb_ms_q;
		logic tick_q;
		logic alert_q;
		logic armed_q;
		logic [4:0] tcnt_q;
		ksc_ar_t ar_q;
		logic [7:0] ar_cnt_q;
		logic [7:0] last_press_q;
		logic push_q;
		logic [7:0] push_data_q;
	} ksc_state_t;
endpackage : ksc_pkg
`default_nettype wire

// file: ksc_cfg.sv
// Key-scan controller configuration, alert, output port and autorepeat
// Behaviour
// R1: Debounce cycle is 9 ms plus code
// R2: Port-enable field maps column drivers to outputs
// R3: All-zero alert config makes alert pin output
// R4: Time trigger fires N cycles after event
// R5: FIFO trigger fires at 2K entries
// R6: Either enabled trigger asserts alert first
// R7: Config bit 5 alone picks release mode; here the cfg_rel_mode input picks it
// R8: Release on FIFO empty or host read
// R9: Output pins driven low by zero bits
// R10: Bits of non-output pins are ignored
// R11: Port register reads back stored value
// R12: Bit 7 enables autorepeat
// R13: Initial delay is (code+1) times eight
// R14: Interval is (code+1) times four
// R15: Push repeat code after delay, then interval
// R16: Held key's press code not re-queued
// R17: One code per interval, restart on events
// R18: Alert pin is active-low open drain
// R19: Delays count whole selected debounce cycles
`default_nettype none
module ksc_cfg #(
	parameter int unsigned CYC_PER_MS = ksc_pkg::MS_CYCLES
) (
	input wire logic clk, // System clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Write data
	output logic [7:0] reg_rdata, // Read data, valid after read
	input wire logic cfg_rel_mode, // Alert release mode select
	input wire logic key_evt_valid, // Debounced key event pulse
	input wire logic key_evt_press, // Event is a press
	input wire logic [7:0] key_evt_data, // Event code
	input wire logic key_any_held, // Some key is held
	input wire logic [4:0] fifo_count, // Entries in event FIFO
	input wire logic fifo_read, // Host read of FIFO pulse
	output logic fifo_push, // Push into event FIFO
	output logic [7:0] fifo_data, // Data to push
	output logic [5:0] col_gpo_en, // Column 7..2 used as output
	output logic [5:0] col_out, // Column output level, always 0
	output logic [5:0] col_oe_n, // Column pull-low enable
	output logic alert_out, // Alert pin level, always 0
	output logic alert_oe_n, // Alert pin pull-low enable
	output logic deb_tick // One pulse per debounce cycle
);
	ksc_pkg::ksc_state_t st_q;
	ksc_pkg::ksc_state_t st_d;
	logic [4:0] deb_code;
	logic [2:0] ports_code;
	logic [4:0] time_n;
	logic [2:0] fifo_k;
	logic alert_cfg_zero;
	logic rpt_en;
	logic [7:0] delay_cycles;
	logic [7:0] rate_cycles;
	logic ms_tick;
	logic time_fire;
	logic fifo_hit;
	logic alert_set;
	logic alert_clr;
	logic suppress;
	logic evt_taken;
	logic rpt_fire;

	// Column outputs enabled from the top column downward
	function automatic logic [5:0] gpo_mask(input logic [2:0] code);
		logic [5:0] m;
		m = 6'h00;
		case (code)
			3'h0: m = 6'h00;
			3'h1: m = 6'h20;
			3'h2: m = 6'h30;
			3'h3: m = 6'h38;
			3'h4: m = 6'h3c;
			3'h5: m = 6'h3e;
			default: m = 6'h3f;
		endcase
		return m;
	endfunction : gpo_mask

	// Field decode
	assign deb_code = st_q.deb_q[ksc_pkg::DEB_TIME_MSB:ksc_pkg::DEB_TIME_LSB];
	assign ports_code =
		st_q.deb_q[ksc_pkg::DEB_PORTS_MSB:ksc_pkg::DEB_PORTS_LSB];
	assign time_n = st_q.alr_q[ksc_pkg::ALR_TIME_MSB:ksc_pkg::ALR_TIME_LSB];
	assign fifo_k = st_q.alr_q[ksc_pkg::ALR_FIFO_MSB:ksc_pkg::ALR_FIFO_LSB];
	assign alert_cfg_zero = (st_q.alr_q == 8'h00);
	assign rpt_en = st_q.rpt_q[ksc_pkg::RPT_EN_BIT];

	// Repeat delay and interval in debounce cycles
	assign delay_cycles = 8'({4'h0,
		st_q.rpt_q[ksc_pkg::RPT_DELAY_MSB:ksc_pkg::RPT_DELAY_LSB]} + 8'h01)
		<< ksc_pkg::DELAY_SHIFT; // R13
	assign rate_cycles = 8'({5'h00,
		st_q.rpt_q[ksc_pkg::RPT_RATE_MSB:ksc_pkg::RPT_RATE_LSB]} + 8'h01)
		<< ksc_pkg::RATE_SHIFT; // R14

	// Timebase and trigger terms
	assign ms_tick = (st_q.ms_cnt_q == 17'(CYC_PER_MS - 1));
	assign time_fire = st_q.tick_q && st_q.armed_q && (time_n != 5'h00) &&
		(st_q.tcnt_q + 5'h01 == time_n); // R4 R19
	assign fifo_hit = (fifo_k != 3'h0) &&
		(fifo_count >= {1'b0, fifo_k, 1'b0}); // R5
	assign alert_set = !alert_cfg_zero && (time_fire || fifo_hit); // R6
	assign alert_clr = cfg_rel_mode ? fifo_read : (fifo_count == 5'h00); // R7 R8

	// Press of the held key is dropped while repeating
	assign suppress = key_evt_press && rpt_en &&
		(st_q.ar_q == ksc_pkg::AR_REPEAT) &&
		(key_evt_data == st_q.last_press_q); // R16
	assign evt_taken = key_evt_valid && !suppress;
	assign rpt_fire = rpt_en && key_any_held && !evt_taken && st_q.tick_q &&
		(((st_q.ar_q == ksc_pkg::AR_DELAY) &&
		(st_q.ar_cnt_q + 8'h01 == delay_cycles)) ||
		((st_q.ar_q == ksc_pkg::AR_REPEAT) &&
		(st_q.ar_cnt_q + 8'h01 == rate_cycles))); // R15 R17

	// Next state of the whole block
	always_comb begin
		st_d = st_q;
		st_d.push_q = 1'b0;
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				ksc_pkg::ADDR_DEBOUNCE: st_d.deb_q = reg_wdata;
				ksc_pkg::ADDR_ALERT_CFG: st_d.alr_q = reg_wdata;
				ksc_pkg::ADDR_PORT_OUT: st_d.port_q =
					reg_wdata & ksc_pkg::PORT_WR_MASK; // R9
				ksc_pkg::ADDR_REPEAT: st_d.rpt_q = reg_wdata;
				default: st_d.rdata_q = st_q.rdata_q;
			endcase
		end
		// Register reads return stored values
		if (reg_rd) begin
			case (reg_addr)
				ksc_pkg::ADDR_DEBOUNCE: st_d.rdata_q = st_q.deb_q;
				ksc_pkg::ADDR_ALERT_CFG: st_d.rdata_q = st_q.alr_q;
				ksc_pkg::ADDR_PORT_OUT: st_d.rdata_q = st_q.port_q; // R11
				ksc_pkg::ADDR_REPEAT: st_d.rdata_q = st_q.rpt_q;
				default: st_d.rdata_q = 8'h00;
			endcase
		end
		// Millisecond and debounce cycle timebase
		st_d.tick_q = 1'b0;
		st_d.ms_cnt_q = ms_tick ? 17'h00000 : st_q.ms_cnt_q + 17'h00001;
		if (ms_tick) begin
			if (st_q.deb_ms_q >= ksc_pkg::DEB_BASE_MS - 6'h01 +
				{1'b0, deb_code}) begin
				st_d.deb_ms_q = 6'h00;
				st_d.tick_q = 1'b1; // R1
			end else begin
				st_d.deb_ms_q = st_q.deb_ms_q + 6'h01;
			end
		end
		// Time-based trigger counts cycles after each key event
		if (evt_taken) begin
			st_d.armed_q = 1'b1;
			st_d.tcnt_q = 5'h00;
		end else if (time_fire) begin
			st_d.armed_q = 1'b0; // R4
		end else if (st_q.tick_q && st_q.armed_q) begin
			st_d.tcnt_q = st_q.tcnt_q + 5'h01; // R19
		end
		// Alert flag, set wins over release
		if (alert_cfg_zero) begin
			st_d.alert_q = 1'b0; // R3
		end else if (alert_set) begin
			st_d.alert_q = 1'b1; // R6
		end else if (alert_clr) begin
			st_d.alert_q = 1'b0; // R8
		end
		// Autorepeat sequencer and FIFO push path
		if (evt_taken) begin
			st_d.push_q = 1'b1;
			st_d.push_data_q = key_evt_data;
			if (key_evt_press) begin
				st_d.last_press_q = key_evt_data;
			end
			st_d.ar_cnt_q = 8'h00;
			st_d.ar_q = (rpt_en && key_any_held) ?
				ksc_pkg::AR_DELAY : ksc_pkg::AR_IDLE; // R17
		end else if (!rpt_en || !key_any_held) begin
			st_d.ar_q = ksc_pkg::AR_IDLE; // R12
			st_d.ar_cnt_q = 8'h00;
		end else if (rpt_fire) begin
			st_d.push_q = 1'b1;
			st_d.push_data_q = ksc_pkg::REPEAT_CODE; // R15
			st_d.ar_q = ksc_pkg::AR_REPEAT;
			st_d.ar_cnt_q = 8'h00;
		end else if (st_q.tick_q) begin
			case (st_q.ar_q)
				ksc_pkg::AR_IDLE: st_d.ar_q = ksc_pkg::AR_DELAY; // R17
				ksc_pkg::AR_DELAY: st_d.ar_cnt_q = st_q.ar_cnt_q + 8'h01;
				ksc_pkg::AR_REPEAT: st_d.ar_cnt_q = st_q.ar_cnt_q + 8'h01;
				default: st_d.ar_q = ksc_pkg::AR_IDLE;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_q <= '0;
			st_q.deb_q <= ksc_pkg::RST_DEBOUNCE;
			st_q.alr_q <= ksc_pkg::RST_ALERT_CFG;
			st_q.port_q <= ksc_pkg::RST_PORT_OUT;
			st_q.rpt_q <= ksc_pkg::RST_REPEAT;
			st_q.ar_q <= ksc_pkg::AR_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Pins and outputs
	assign col_gpo_en = gpo_mask(ports_code); // R2
	assign col_out = 6'h00;
	assign col_oe_n = ~col_gpo_en |
		st_q.port_q[ksc_pkg::PORT_COL_MSB:ksc_pkg::PORT_COL_LSB]; // R9 R10
	assign alert_out = 1'b0;
	assign alert_oe_n = alert_cfg_zero ?
		st_q.port_q[ksc_pkg::PORT_ALERT_BIT] : !st_q.alert_q; // R3 R18
	assign reg_rdata = st_q.rdata_q;
	assign fifo_push = st_q.push_q;
	assign fifo_data = st_q.push_data_q;
	assign deb_tick = st_q.tick_q;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_fifo_hit;
		!alert_cfg_zero && fifo_hit;
	endsequence
	sequence s_rpt_due;
		rpt_fire;
	endsequence
	sequence s_held_press;
		key_evt_valid && suppress;
	endsequence

	AST_PORT_READ: assert property ( // R11
		reg_rd && !reg_wr && reg_addr == ksc_pkg::ADDR_PORT_OUT |=>
		reg_rdata == $past(st_q.port_q))
		else $error("port read differs from stored value");
	AST_ALERT_GPO: assert property ( // R3
		alert_cfg_zero |-> alert_oe_n == st_q.port_q[ksc_pkg::PORT_ALERT_BIT])
		else $error("alert pin not following port bit");
	AST_ALERT_PIN: assert property ( // R18
		!alert_cfg_zero |-> alert_oe_n == !st_q.alert_q && alert_out == 1'b0)
		else $error("alert pin drive wrong");
	AST_FIFO_TRIG: assert property ( // R5
		s_fifo_hit |=> st_q.alert_q)
		else $error("fifo depth trigger missed");
	AST_TIME_TRIG: assert property ( // R4
		!alert_cfg_zero && time_fire && !evt_taken |=>
		st_q.alert_q && !st_q.armed_q)
		else $error("time trigger missed");
	AST_RELEASE_EMPTY: assert property ( // R8
		!cfg_rel_mode && fifo_count == 5'h00 && !alert_set |=> !st_q.alert_q)
		else $error("alert not released on empty fifo");
	AST_COL_IGNORE: assert property ( // R10
		(col_oe_n | col_gpo_en) == 6'h3f)
		else $error("non-output column driven");
	AST_REPEAT_PUSH: assert property ( // R15
		s_rpt_due |=> fifo_push && fifo_data == ksc_pkg::REPEAT_CODE)
		else $error("repeat code not pushed");
	AST_NO_REPRESS: assert property ( // R16
		s_held_press and !rpt_fire |=> !fifo_push)
		else $error("held key press re-queued");
	AST_RPT_OFF: assert property ( // R12
		!rpt_en |=> st_q.ar_q == ksc_pkg::AR_IDLE ##1 !rpt_en [*2] |->
		!(fifo_push && fifo_data == ksc_pkg::REPEAT_CODE))
		else $error("repeat while disabled");
endmodule : ksc_cfg
`default_nettype wire

// file: ksc_fifo_model.sv
// Event FIFO occupancy model on the far side of the block
`default_nettype none
module ksc_fifo_model (
	input wire logic clk, // System clock
	input wire logic rstn, // Reset, active low
	input wire logic push, // Entry written
	input wire logic read, // Entry taken by host
	output logic [4:0] count // Entries held
);
	timeunit 1ns;
	timeprecision 1ns;
	// Occupancy counter, clamped at empty and at sixteen entries
	always_ff @(posedge clk) begin
		if (!rstn) count <= 5'h00;
		else if (push && !read && count != 5'h10) count <= count + 5'h01;
		else if (read && !push && count != 5'h00) count <= count - 5'h01;
	end
endmodule : ksc_fifo_model
`default_nettype wire

// file: test_keyscan_irq_gpo_autorepeat_cfg.sv
// Self-checking bench for the key-scan configuration block
`default_nettype none
module test_keyscan_irq_gpo_autorepeat_cfg;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, fifo_data;
	logic rel = 1'b0, kv = 1'b0, kp = 1'b0, held = 1'b0, fread = 1'b0;
	logic [7:0] kd = 8'h00, pv;
	logic [4:0] fcnt;
	logic push, alert_oe_n, rd_d = 1'b0;
	logic [5:0] gpo_en, col_oe_n, m, cout;
	logic dtk;
	int n = 0;
	logic [7:0] rq[$], pq[$];
	int num_errors = 0, cmp_count = 0, cyc = 0, t_last = 0, t_gap = 0;
	// Clock
	always #5 clk = ~clk;
	ksc_cfg #(.CYC_PER_MS(10)) dut (.clk(clk), .rstn(rstn),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_rel_mode(rel),
		.key_evt_valid(kv), .key_evt_press(kp), .key_evt_data(kd),
		.key_any_held(held), .fifo_count(fcnt), .fifo_read(fread),
		.fifo_push(push), .fifo_data(fifo_data), .col_gpo_en(gpo_en),
		.col_out(cout), .col_oe_n(col_oe_n), .alert_out(),
		.alert_oe_n(alert_oe_n), .deb_tick(dtk));
	ksc_fifo_model fifo (.clk(clk), .rstn(rstn), .push(push),
		.read(fread), .count(fcnt));
	task automatic summarize;
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd
	// Key event, its code expected as the next push
	task automatic evt(input logic p, input logic [7:0] d);
		pq.push_back(d);
		@(posedge clk);
		kv <= 1'b1;
		kp <= p;
		kd <= d;
		@(posedge clk);
		kv <= 1'b0;
	endtask : evt
	task automatic hread;
		@(posedge clk);
		fread <= 1'b1;
		@(posedge clk);
		fread <= 1'b0;
	endtask : hread
	task automatic wait_alert(input logic v);
		int i;
		for (i = 0; i < 400 && alert_oe_n !== v; i++) @(posedge clk);
		if (i == 400) begin
			num_errors++;
			summarize();
		end
		chk({7'h00, alert_oe_n}, {7'h00, v});
	endtask : wait_alert
	task automatic wait_q;
		int i;
		for (i = 0; i < 1500 && pq.size() != 0; i++) @(posedge clk);
		if (i == 1500) begin
			num_errors++;
			summarize();
		end
		@(posedge clk);
	endtask : wait_q
	// Watcher: read data one edge after the taken strobe, pushes in order
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rd_d) chk(reg_rdata, rq.pop_front());
		rd_d <= reg_rd;
		if (push === 1'b1) begin
			t_gap <= cyc - t_last;
			t_last <= cyc;
			if (pq.size() != 0) chk(fifo_data, pq.pop_front());
			else chk(fifo_data, 8'hxx);
		end
	end
	initial begin
		void'($urandom(33));
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		// Reset values and an unmapped address
		rd(8'h02, 8'hff);
		rd(8'h03, 8'h00);
		rd(8'h04, 8'hfe);
		rd(8'h05, 8'h00);
		rd(8'h07, 8'h00);
		// Every port-enable code with a random port pattern
		for (int c = 0; c < 8; c++) begin
			pv = 8'($urandom);
			m = 6'(6'h3f << (6 - (c > 6 ? 6 : c)));
			wr(8'h02, {3'(c), 5'h00});
			wr(8'h04, pv);
			rd(8'h04, pv & 8'hfe);
			chk({2'h0, gpo_en}, {2'h0, m});
			chk({2'h0, col_oe_n}, {2'h0, ~m | pv[7:2]});
			chk({7'h00, alert_oe_n}, {7'h00, pv[1]});
			chk({2'h0, cout}, 8'h00);
		end
		// Held key: delay, repeat code, dropped re-press, release
		wr(8'h02, 8'h00);
		// Debounce cycle of code zero is nine ms of ten clocks each
		for (int i = 0; i < 200 && dtk !== 1'b1; i++) @(posedge clk);
		@(posedge clk);
		for (n = 1; n < 200 && dtk !== 1'b1; n++) @(posedge clk);
		chk(8'(n), 8'h5a);
		wr(8'h05, 8'h80);
		held <= 1'b1;
		evt(1'b1, 8'h21);
		pq.push_back(8'h7e);
		wait_q;
		// Eight cycles of 90 clocks, the first one partial
		chk({7'h00, t_gap >= 631 && t_gap <= 720}, 8'h01);
		pq.push_back(8'h7e);
		evt(1'b1, 8'h21);
		pq.pop_back();
		wait_q;
		chk(8'(t_gap - 300), 8'h3c);
		held <= 1'b0;
		evt(1'b0, 8'ha1);
		wait_q;
		repeat (400) @(posedge clk);
		// Depth trigger, release on empty, then on host read
		wr(8'h05, 8'h00);
		repeat (20) hread;
		wr(8'h03, 8'h20);
		evt(1'b0, 8'h11);
		evt(1'b0, 8'h12);
		wait_alert(1'b0);
		repeat (2) hread;
		wait_alert(1'b1);
		rel <= 1'b1;
		evt(1'b0, 8'h13);
		evt(1'b0, 8'h14);
		wait_alert(1'b0);
		// First read meets a still-met depth condition, so set wins
		repeat (2) hread;
		wait_alert(1'b1);
		// Time trigger after three debounce cycles
		rel <= 1'b0;
		hread;
		wr(8'h03, 8'h03);
		evt(1'b0, 8'h15);
		repeat (175) @(posedge clk);
		chk({7'h00, alert_oe_n}, 8'h01);
		wait_alert(1'b0);
		summarize();
	end
endmodule : test_keyscan_irq_gpo_autorepeat_cfg
`default_nettype wire
